// ### verilog/scp_pkg.sv
/*
 * constants for the serial configuration port and lo/rf control block:
 * register offsets, field positions, reset values and crossing depths.
 * assumes a 200 MHz apb clock and a serial clock from the host controller.
 */
// Notes on behaviour
// - sdata shifts into 24-bit register on rising sclk
// - strobe rise copies word to one of six registers
// - three control bits in word pick the destination
// - lo pins input when select and drive low
// - external lo reaches modulator only with route bit
// - lo pins drive when select or drive bit high
// - divide bit picks 1x (1) or 2x (0) lo
// - rf output on only when pin and bit 6
// - lo pins present internal lo, else accept external
package scp_pkg;

    // ------------------------------------------------------------------
    // serial word layout
    // ------------------------------------------------------------------
    localparam int unsigned WORD_W        = 24;
    localparam int unsigned SEL_W         = 3;
    localparam int unsigned NUM_CFG       = 6;
    localparam logic [2:0]  LO_CFG_IDX    = 3'h5;
    localparam int unsigned LO_DRIVE_BIT  = 3;
    localparam int unsigned EXT_ROUTE_BIT = 4;
    localparam int unsigned LO_DIVIDE_BIT = 5;
    localparam int unsigned RFEN_BIT      = 6;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int unsigned PCLK_PERIOD_PS     = 5000;
    localparam int unsigned SCLK_MIN_PERIOD_PS = 50000;
    localparam int unsigned SCLK_MIN_CYCLES    = (SCLK_MIN_PERIOD_PS + PCLK_PERIOD_PS - 1) / PCLK_PERIOD_PS;
    localparam int unsigned SYNC_STAGES        = 2;

    // ------------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [11:0] CFG0_OFS   = 12'h000;
    localparam logic [11:0] STATUS_OFS = 12'h018;
    localparam logic [11:0] CTRL_OFS   = 12'h01c;
    localparam logic [11:0] LAST_OFS   = 12'h020;
    localparam logic [11:0] COUNT_OFS  = 12'h024;

    localparam logic [23:0] CFG_RST    = 24'h000000;
    localparam logic [0:0]  CTRL_RST   = 1'h1;
    localparam logic [15:0] COUNT_RST  = 16'h0000;

    // status bit positions
    localparam int unsigned ST_LO_OUT  = 0;
    localparam int unsigned ST_LO_IN   = 1;
    localparam int unsigned ST_EXT_LO  = 2;
    localparam int unsigned ST_DIV1X   = 3;
    localparam int unsigned ST_RF_EN   = 4;
    localparam int unsigned ST_DIRPIN  = 5;
    localparam int unsigned ST_ENPIN   = 6;
    localparam int unsigned ST_STROBE  = 7;
    localparam int unsigned ST_BADSEL  = 8;

endpackage : scp_pkg

// ### verilog/scp_lo_ctrl.sv
/*
 * serial configuration port with lo direction and rf output decode.
 * assumes an apb master on pclk, and a host that drives sclk, sdata and
 * load_strobe; sclk stays idle while load_strobe is high.
 */
`timescale 1ns/1ps
`default_nettype none

module scp_lo_ctrl (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [11:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        sclk,
    input  wire logic        sdata,
    input  wire logic        load_strobe,
    input  wire logic        rf_output_enable_pin,
    input  wire logic        lo_direction_select,
    input  wire logic        lo_gen_1x,
    input  wire logic        lo_gen_2x,
    input  wire logic        lo_port_positive_in,
    output logic             lo_port_positive_out,
    output logic             lo_port_positive_oe_n,
    input  wire logic        lo_port_negative_in,
    output logic             lo_port_negative_out,
    output logic             lo_port_negative_oe_n,
    output logic             mod_lo_external,
    output logic             lo_out_div1x,
    output logic             rf_output
);

    // ------------------------------------------------------------------
    // serial shift register, link clock domain
    // ------------------------------------------------------------------
    logic [23:0] sreg_r;
    logic [23:0] sreg_nxt;

    always_comb begin
        sreg_nxt = {sreg_r[22:0], sdata};
    end

    always_ff @(posedge sclk or negedge presetn) begin
        if (!presetn) begin
            sreg_r <= scp_pkg::CFG_RST;
        end else begin
            sreg_r <= sreg_nxt;
        end
    end

    chk_shift_in: assert property (@(posedge sclk) disable iff (!presetn)
        1'b1 |=> sreg_r == {$past(sreg_r[22:0]), $past(sdata)})
        else $error("shift register did not take serial bit");

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    logic [2:0] pin_s1_r;
    logic [2:0] pin_s2_r;
    logic [2:0] pin_s1_nxt;
    logic [2:0] pin_s2_nxt;
    logic       strobe_d_r;
    logic       strobe_d_nxt;

    always_comb begin
        pin_s1_nxt   = {load_strobe, rf_output_enable_pin, lo_direction_select};
        pin_s2_nxt   = pin_s1_r;
        strobe_d_nxt = pin_s2_r[2];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_s1_r   <= 3'h0;
            pin_s2_r   <= 3'h0;
            strobe_d_r <= 1'h0;
        end else begin
            pin_s1_r   <= pin_s1_nxt;
            pin_s2_r   <= pin_s2_nxt;
            strobe_d_r <= strobe_d_nxt;
        end
    end

    chk_pin_sync: assert property (@(posedge pclk) disable iff (!presetn)
        pin_s2_r == $past(pin_s1_nxt, 2))
        else $error("pin synchroniser delay wrong");

    logic       dir_pin;
    logic       rfen_pin;
    logic       strobe_s;
    logic       strobe_rise;
    logic       load_en_r;
    logic       load_evt;
    logic [2:0] word_sel;
    logic       sel_ok;

    // the shifted word is static by the time the strobe clears the synchroniser
    assign dir_pin     = pin_s2_r[0];
    assign rfen_pin    = pin_s2_r[1];
    assign strobe_s    = pin_s2_r[2];
    assign strobe_rise = strobe_s & ~strobe_d_r;
    assign load_evt    = strobe_rise & load_en_r;
    assign word_sel    = sreg_r[2:0];
    assign sel_ok      = (word_sel < 3'(scp_pkg::NUM_CFG));

    // ------------------------------------------------------------------
    // six configuration registers
    // ------------------------------------------------------------------
    logic [23:0] cfg_r [scp_pkg::NUM_CFG];

    for (genvar gi = 0; gi < scp_pkg::NUM_CFG; gi++) begin : g_cfg
        logic [23:0] cfg_nxt;

        always_comb begin
            cfg_nxt = cfg_r[gi];
            if (load_evt && word_sel == 3'(gi)) begin
                cfg_nxt = sreg_r;
            end
        end

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                cfg_r[gi] <= scp_pkg::CFG_RST;
            end else begin
                cfg_r[gi] <= cfg_nxt;
            end
        end

        chk_cfg_load: assert property (@(posedge pclk) disable iff (!presetn)
            (load_evt && word_sel == 3'(gi)) |=> (cfg_r[gi] == $past(sreg_r)))
            else $error("latched word missing from selected register");

        chk_cfg_hold: assert property (@(posedge pclk) disable iff (!presetn)
            !(load_evt && word_sel == 3'(gi)) |=> $stable(cfg_r[gi]))
            else $error("register changed without a strobe to it");
    end

    // ------------------------------------------------------------------
    // lo and rf decode
    // ------------------------------------------------------------------
    logic [23:0] lo_cfg;
    logic        lo_out_r;
    logic        lo_out_nxt;
    logic        ext_lo_r;
    logic        ext_lo_nxt;
    logic        div1x_r;
    logic        div1x_nxt;
    logic        rf_r;
    logic        rf_nxt;

    assign lo_cfg = cfg_r[scp_pkg::LO_CFG_IDX];

    always_comb begin
        lo_out_nxt = dir_pin | lo_cfg[scp_pkg::LO_DRIVE_BIT];
        ext_lo_nxt = ~lo_out_nxt & lo_cfg[scp_pkg::EXT_ROUTE_BIT];
        div1x_nxt  = lo_cfg[scp_pkg::LO_DIVIDE_BIT];
        rf_nxt     = rfen_pin & lo_cfg[scp_pkg::RFEN_BIT];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lo_out_r <= 1'h0;
            ext_lo_r <= 1'h0;
            div1x_r  <= 1'h0;
            rf_r     <= 1'h0;
        end else begin
            lo_out_r <= lo_out_nxt;
            ext_lo_r <= ext_lo_nxt;
            div1x_r  <= div1x_nxt;
            rf_r     <= rf_nxt;
        end
    end

    logic lo_sel;

    // internal lo goes out only while driving; otherwise pins are left to the far end
    assign lo_sel                = div1x_r ? lo_gen_1x : lo_gen_2x;
    assign lo_port_positive_out  = lo_out_r & lo_sel;
    assign lo_port_negative_out  = lo_out_r & ~lo_sel;
    assign lo_port_positive_oe_n = ~lo_out_r;
    assign lo_port_negative_oe_n = ~lo_out_r;
    assign mod_lo_external       = ext_lo_r;
    assign lo_out_div1x          = div1x_r;
    assign rf_output             = rf_r;

    chk_lo_input: assert property (@(posedge pclk) disable iff (!presetn)
        (!dir_pin && !lo_cfg[scp_pkg::LO_DRIVE_BIT]) |=> lo_port_positive_oe_n && lo_port_negative_oe_n)
        else $error("lo pins not released as inputs");

    chk_lo_output: assert property (@(posedge pclk) disable iff (!presetn)
        (dir_pin || lo_cfg[scp_pkg::LO_DRIVE_BIT]) |=> !lo_port_positive_oe_n && !lo_port_negative_oe_n)
        else $error("lo pins not driven as outputs");

    chk_ext_route: assert property (@(posedge pclk) disable iff (!presetn)
        mod_lo_external == $past(!dir_pin && !lo_cfg[scp_pkg::LO_DRIVE_BIT] && lo_cfg[scp_pkg::EXT_ROUTE_BIT]))
        else $error("external lo route wrong");

    chk_div_sel: assert property (@(posedge pclk) disable iff (!presetn)
        lo_out_div1x == $past(lo_cfg[scp_pkg::LO_DIVIDE_BIT]))
        else $error("lo divide select wrong");

    chk_rf_enable: assert property (@(posedge pclk) disable iff (!presetn)
        rf_output == $past(rfen_pin && lo_cfg[scp_pkg::RFEN_BIT]))
        else $error("rf output enable wrong");

    chk_lo_present: assert property (@(posedge pclk) disable iff (!presetn)
        lo_port_positive_oe_n |-> !lo_port_positive_out && !lo_port_negative_out)
        else $error("lo driven while pins are inputs");

    chk_strobe_lat: assert property (@(posedge pclk) disable iff (!presetn)
        ($rose(pin_s1_r[2]) ##1 load_en_r) |-> load_evt)
        else $error("strobe not taken after synchroniser");

    chk_decode_hold: assert property (@(posedge pclk) disable iff (!presetn)
        ($stable(lo_cfg) && $stable(dir_pin) && $stable(rfen_pin))
        |=> ($stable(rf_output) && $stable(lo_out_div1x) && $stable(mod_lo_external) && $stable(lo_port_positive_oe_n)))
        else $error("decoded controls changed with no cause");

    // ------------------------------------------------------------------
    // apb slave: ctrl, last word, counter and status
    // ------------------------------------------------------------------
    logic        setup;
    logic        wr_acc;
    logic        load_en_nxt;
    logic [23:0] last_r;
    logic [23:0] last_nxt;
    logic        badsel_r;
    logic        badsel_nxt;
    logic [15:0] count_r;
    logic [15:0] count_nxt;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic        err_r;
    logic        err_nxt;
    logic [31:0] status;
    logic [31:0] rd_mux;
    logic        hit;

    assign setup  = psel & ~penable;
    assign wr_acc = psel & penable & pwrite & ~err_r;

    always_comb begin
        status                       = 32'h0;
        status[scp_pkg::ST_LO_OUT]   = lo_out_r;
        status[scp_pkg::ST_LO_IN]    = ~lo_out_r;
        status[scp_pkg::ST_EXT_LO]   = ext_lo_r;
        status[scp_pkg::ST_DIV1X]    = div1x_r;
        status[scp_pkg::ST_RF_EN]    = rf_r;
        status[scp_pkg::ST_DIRPIN]   = dir_pin;
        status[scp_pkg::ST_ENPIN]    = rfen_pin;
        status[scp_pkg::ST_STROBE]   = strobe_s;
        status[scp_pkg::ST_BADSEL]   = badsel_r;
    end

    always_comb begin
        rd_mux = 32'h0;
        hit    = 1'b1;
        if (paddr[1:0] != 2'h0) begin
            hit = 1'b0;
        end else if (paddr < scp_pkg::STATUS_OFS) begin
            rd_mux = {8'h00, cfg_r[paddr[4:2]]};
        end else if (paddr == scp_pkg::STATUS_OFS) begin
            rd_mux = status;
        end else if (paddr == scp_pkg::CTRL_OFS) begin
            rd_mux = {31'h0, load_en_r};
        end else if (paddr == scp_pkg::LAST_OFS) begin
            rd_mux = {8'h00, last_r};
        end else if (paddr == scp_pkg::COUNT_OFS) begin
            rd_mux = {16'h0000, count_r};
        end else begin
            hit = 1'b0;
        end
    end

    always_comb begin
        rdata_nxt   = rdata_r;
        err_nxt     = err_r;
        load_en_nxt = load_en_r;
        last_nxt    = last_r;
        badsel_nxt  = badsel_r;
        count_nxt   = count_r;
        if (setup) begin
            rdata_nxt = pwrite ? 32'h0 : rd_mux;
            err_nxt   = ~hit;
        end
        if (wr_acc && paddr == scp_pkg::CTRL_OFS && pstrb[0]) begin
            load_en_nxt = pwdata[0];
        end
        if (load_evt) begin
            last_nxt   = sreg_r;
            badsel_nxt = ~sel_ok;
            count_nxt  = count_r + 16'h0001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_r   <= 32'h0;
            err_r     <= 1'h0;
            load_en_r <= scp_pkg::CTRL_RST;
            last_r    <= scp_pkg::CFG_RST;
            badsel_r  <= 1'h0;
            count_r   <= scp_pkg::COUNT_RST;
        end else begin
            rdata_r   <= rdata_nxt;
            err_r     <= err_nxt;
            load_en_r <= load_en_nxt;
            last_r    <= last_nxt;
            badsel_r  <= badsel_nxt;
            count_r   <= count_nxt;
        end
    end

    // ------------------------------------------------------------------
    // latch bookkeeping and apb checks
    // ------------------------------------------------------------------
    chk_badsel_set: assert property (@(posedge pclk) disable iff (!presetn)
        load_evt |=> badsel_r == ($past(word_sel) >= 3'(scp_pkg::NUM_CFG)))
        else $error("bad select flag wrong after latch");

    chk_count_step: assert property (@(posedge pclk) disable iff (!presetn)
        load_evt |=> count_r == $past(count_r) + 16'h0001)
        else $error("load count did not step");

    chk_count_hold: assert property (@(posedge pclk) disable iff (!presetn)
        !load_evt |=> $stable(count_r) && $stable(last_r))
        else $error("latch record changed without a strobe");

    chk_ctrl_write: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_acc && paddr == scp_pkg::CTRL_OFS && pstrb[0]) |=> load_en_r == $past(pwdata[0]))
        else $error("control write not applied");

    chk_bad_addr: assert property (@(posedge pclk) disable iff (!presetn)
        (setup && paddr[1:0] != 2'h0) |=> err_r)
        else $error("unaligned access not refused");

    assign pready  = 1'b1;
    assign prdata  = rdata_r;
    assign pslverr = psel & penable & err_r;

endmodule : scp_lo_ctrl

`default_nettype wire

// ### sim/scp_host_model.sv
/*
 * host controller model: drives the serial clock, data and load strobe.
 * assumes the bench calls send_word from one process at a time.
 */
`timescale 1ns/1ps
`default_nettype none

module scp_host_model (
    output logic sclk,
    output logic sdata,
    output logic load_strobe
);
    initial begin
        sclk = 1'b0;
        sdata = 1'b0;
        load_strobe = 1'b0;
    end

    // one 24-bit word at 12.5 MHz; sclk stands still outside frames
    task automatic send_word(input logic [23:0] word, input logic strobe);
        #3.3;
        for (int i = 23; i >= 0; i--) begin
            sdata = word[i];
            #40 sclk = 1'b1;
            #40 sclk = 1'b0;
        end
        sdata = ~word[0];
        #40 load_strobe = strobe;
        #80 load_strobe = 1'b0;
        #40;
    endtask : send_word
endmodule : scp_host_model

`default_nettype wire

// ### sim/serial_config_port_lo_control_bench.sv
/*
 * self-checking bench for the serial port and lo/rf decode block.
 * assumes scp_host_model on the link side and an apb master task here.
 */
`timescale 1ns/1ps
`default_nettype none

module serial_config_port_lo_control_bench;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        sclk, sdata, load_strobe, en_pin, dir_pin, gen1, gen2, ext_lo;
    logic        p_out, p_oe_n, n_out, n_oe_n, p_wire, n_wire, mod_ext, div1x, rf_out, err;
    int          num_errors, num_checks;

    // lo pin wires resolved from both drivers
    assign p_wire = p_oe_n ? ext_lo : p_out;
    assign n_wire = n_oe_n ? ~ext_lo : n_out;

    scp_lo_ctrl dut_u (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sclk(sclk), .sdata(sdata), .load_strobe(load_strobe),
        .rf_output_enable_pin(en_pin), .lo_direction_select(dir_pin), .lo_gen_1x(gen1),
        .lo_gen_2x(gen2), .lo_port_positive_in(p_wire), .lo_port_positive_out(p_out),
        .lo_port_positive_oe_n(p_oe_n), .lo_port_negative_in(n_wire),
        .lo_port_negative_out(n_out), .lo_port_negative_oe_n(n_oe_n),
        .mod_lo_external(mod_ext), .lo_out_div1x(div1x), .rf_output(rf_out)
    );

    scp_host_model host_u (
        .sclk(sclk), .sdata(sdata), .load_strobe(load_strobe)
    );

    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        chk(32'(n), 32'h1, "apb wait states");
    endtask : apb

    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp, "register read");
    endtask : rdchk

    task automatic stop_test();
        $display("errors %0d checks %0d", num_errors, num_checks);
        if (num_errors == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : stop_test

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic test_reset();
        for (int i = 0; i < 6; i++) rdchk(12'(4 * i), 32'h0);
        rdchk(scp_pkg::CTRL_OFS, 32'h1);
        chk(32'({p_oe_n, n_oe_n, rf_out, mod_ext}), 32'hc, "reset pins");
    endtask : test_reset

    task automatic test_load();
        logic [23:0] w [6];
        for (int i = 0; i < 6; i++) begin
            w[i] = {16'hc3a5 ^ 16'(i * 4369), 5'(i), 3'(i)};
            host_u.send_word(w[i], 1'b1);
        end
        for (int i = 0; i < 6; i++) rdchk(12'(4 * i), 32'(w[i]));
        rdchk(scp_pkg::COUNT_OFS, 32'h6);
        rdchk(scp_pkg::LAST_OFS, 32'(w[5]));
        host_u.send_word(24'h00ff00, 1'b0);
        rdchk(scp_pkg::CFG0_OFS, 32'(w[0]));
        rdchk(scp_pkg::COUNT_OFS, 32'h6);
        chk(32'({p_oe_n, div1x}), 32'h1, "held decode");
    endtask : test_load

    task automatic test_refuse();
        logic [31:0] c0;
        rdchk(12'h100, 32'h0);
        chk(32'(err), 32'h1, "unmapped error");
        apb(1'b0, 12'h002, 32'h0);
        chk(32'(err), 32'h1, "unaligned error");
        apb(1'b0, scp_pkg::CFG0_OFS, 32'h0);
        c0 = rd;
        apb(1'b1, scp_pkg::CFG0_OFS, 32'h00ffffff);
        host_u.send_word(24'h123456, 1'b1);
        host_u.send_word(24'h12345f, 1'b1);
        apb(1'b0, scp_pkg::STATUS_OFS, 32'h0);
        chk(32'(rd[scp_pkg::ST_BADSEL]), 32'h1, "bad select flag");
        rdchk(scp_pkg::CFG0_OFS, c0);
        rdchk(scp_pkg::COUNT_OFS, 32'h8);
        apb(1'b1, scp_pkg::CTRL_OFS, 32'h0);
        host_u.send_word(24'h777770, 1'b1);
        rdchk(scp_pkg::CFG0_OFS, c0);
        apb(1'b1, scp_pkg::CTRL_OFS, 32'h1);
        rdchk(scp_pkg::CTRL_OFS, 32'h1);
    endtask : test_refuse

    task automatic test_lo_modes();
        logic o;
        logic l;
        for (int v = 0; v < 16; v++) begin
            host_u.send_word({17'h0, 4'(v), 3'h5}, 1'b1);
            for (int p = 0; p < 4; p++) begin
                @(posedge pclk);
                dir_pin <= p[0];
                en_pin <= p[1];
                gen1 <= ~p[1];
                gen2 <= p[1];
                repeat (6) @(posedge pclk);
                o = p[0] | v[0];
                l = v[2] ^ p[1];
                chk(32'({p_oe_n, n_oe_n, mod_ext, div1x, rf_out, p_out, n_out}),
                    32'({~o, ~o, ~o & v[1], v[2], p[1] & v[3], o & l, o & ~l}),
                    "lo decode");
            end
            rdchk(scp_pkg::STATUS_OFS, 32'({4'h3, v[3], v[2], 3'h1}));
        end
    endtask : test_lo_modes

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        en_pin = 1'b0;
        dir_pin = 1'b0;
        gen1 = 1'b1;
        gen2 = 1'b0;
        ext_lo = 1'b0;
        num_errors = 0;
        num_checks = 0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        test_reset();
        test_load();
        test_refuse();
        test_lo_modes();
        stop_test();
    end

    initial begin
        #400us;
        num_errors++;
        $display("BAD %0t watchdog expired", $time);
        stop_test();
    end
endmodule : serial_config_port_lo_control_bench

`default_nettype wire
